// *** async_pwm_timer_pkg.sv ***
package async_pwm_timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_COMPARE = 8'h23;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  localparam logic [7:0] IDX_COUNT = 8'h24;
  localparam logic [7:0] IDX_CONTROL = 8'h25;
  localparam logic [7:0] IDX_FLAGS = 8'h38;
  localparam logic [7:0] IDX_MASK = 8'h39;

  // Status register fields
  localparam int STAT_ASYNC_BIT = 3;
  localparam int STAT_COUNT_BUSY_BIT = 2;
  localparam int STAT_COMPARE_BUSY_BIT = 1;
  localparam int STAT_CONTROL_BUSY_BIT = 0;

  // Control register fields
  localparam int CTRL_PWM_BIT = 6;
  localparam int CTRL_MODE_HI_BIT = 5;
  localparam int CTRL_MODE_LO_BIT = 4;
  localparam int CTRL_CTC_BIT = 3;
  localparam int CTRL_CS_HI_BIT = 2;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;

  // Flag and mask register fields
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int MASK_GLOBAL_BIT = 7;

  // Staging entries, numbered as their busy bits
  localparam int ENTRY_CONTROL = 0;
  localparam int ENTRY_COMPARE = 1;
  localparam int ENTRY_COUNT = 2;
  localparam int ENTRY_NUM = 3;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Counter limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hFF;

  // Timing
  localparam logic [1:0] TRANSFER_EDGES = 2'h2;
  localparam int FLAG_SYNC_CYCLES = 3;

  // Prescaler terminal counts (divisor minus one)
  localparam logic [9:0] DIV1_LAST = 10'h000;
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV32_LAST = 10'h01F;
  localparam logic [9:0] DIV64_LAST = 10'h03F;
  localparam logic [9:0] DIV128_LAST = 10'h07F;
  localparam logic [9:0] DIV256_LAST = 10'h0FF;
  localparam logic [9:0] DIV1024_LAST = 10'h3FF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] mode;
    logic pwm;
    logic ctc;
    logic [2:0] cs;
  } control_fields_s;

  typedef struct packed {
    logic ovf;
    logic cmp;
  } timer_events_s;

endpackage

// *** async_pwm_timer.sv ***
`timescale 1ns/1ps

module async_pwm_timer
  import async_pwm_timer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator and power
  input wire logic ext_osc_input,
  input wire logic power_down,
  output logic osc_pins_claimed,
  output logic osc_run,
  // Compare pin and requests
  output logic compare_output_pin,
  output logic compare_output_oe,
  output logic overflow_irq_req,
  output logic compare_irq_req,
  output logic wake_req
);

  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // Bus state
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] wr_idx_q;
  logic [1:0] wr_lo_q;
  logic [7:0] wr_data_q;
  logic wr_lane_q;
  logic wr_fire;
  logic wr_hit_status;
  logic wr_hit_flags;
  logic wr_hit_mask;
  logic [ENTRY_NUM-1:0] wr_hit;
  logic wr_known;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_known;

  // Timer state
  logic async_sel_q;
  logic [7:0] mask_q;
  logic [7:0] flags_q;
  logic [7:0] stage_q [ENTRY_NUM];
  logic [ENTRY_NUM-1:0] busy_q;
  logic [1:0] edges_q [ENTRY_NUM];
  logic [ENTRY_NUM-1:0] load;
  logic [7:0] load_val [ENTRY_NUM];
  logic [7:0] control_q;
  logic [7:0] compare_hold_q;
  logic [7:0] compare_act_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic dir_up_q;
  logic dir_up_d;
  logic [9:0] presc_q;
  logic [9:0] presc_last;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic osc_rise;
  logic src_tick;
  logic tick;
  logic match;
  timer_events_s ev;
  timer_events_s ev_pipe_q [FLAG_SYNC_CYCLES];
  timer_events_s ev_set;
  control_fields_s ctl;
  logic irq_ovf;
  logic irq_cmp;

  assign ctl.mode = control_q[CTRL_MODE_HI_BIT:CTRL_MODE_LO_BIT];
  assign ctl.pwm = control_q[CTRL_PWM_BIT];
  assign ctl.ctc = control_q[CTRL_CTC_BIT];
  assign ctl.cs = control_q[CTRL_CS_HI_BIT:0];

  // Write channel: address and data taken in either order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      wr_idx_q <= RESET_BYTE;
      wr_lo_q <= 2'h0;
      wr_data_q <= RESET_BYTE;
      wr_lane_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        wr_idx_q <= {2'h0, s_axi_awaddr[7:2]};
        wr_lo_q <= s_axi_awaddr[1:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wr_data_q <= s_axi_wdata[7:0];
        wr_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready stays low from a taken beat until its response is accepted
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_known = (wr_lo_q == 2'h0) && (wr_idx_q == IDX_STATUS || wr_idx_q == IDX_COMPARE
    || wr_idx_q == IDX_COUNT || wr_idx_q == IDX_CONTROL || wr_idx_q == IDX_FLAGS
    || wr_idx_q == IDX_MASK);
  // Byte lane 0 only; other lanes carry nothing
  assign wr_hit_status = wr_fire && wr_known && wr_lane_q && wr_idx_q == IDX_STATUS;
  assign wr_hit_flags = wr_fire && wr_known && wr_lane_q && wr_idx_q == IDX_FLAGS;
  assign wr_hit_mask = wr_fire && wr_known && wr_lane_q && wr_idx_q == IDX_MASK;
  assign wr_hit[ENTRY_CONTROL] = wr_fire && wr_known && wr_lane_q && wr_idx_q == IDX_CONTROL;
  assign wr_hit[ENTRY_COMPARE] = wr_fire && wr_known && wr_lane_q && wr_idx_q == IDX_COMPARE;
  assign wr_hit[ENTRY_COUNT] = wr_fire && wr_known && wr_lane_q && wr_idx_q == IDX_COUNT;

  // Read channel
  assign rd_idx = {2'h0, s_axi_araddr[7:2]};
  assign rd_known = (s_axi_araddr[1:0] == 2'h0) && (rd_idx == IDX_STATUS
    || rd_idx == IDX_COMPARE || rd_idx == IDX_COUNT || rd_idx == IDX_CONTROL
    || rd_idx == IDX_FLAGS || rd_idx == IDX_MASK);

  always_comb begin
    rd_byte = RESET_BYTE;
    case (rd_idx)
      IDX_STATUS: rd_byte = {4'h0, async_sel_q, busy_q};
      IDX_CONTROL: rd_byte = stage_q[ENTRY_CONTROL] & CTRL_WRITE_MASK;
      IDX_COMPARE: rd_byte = stage_q[ENTRY_COMPARE];
      IDX_COUNT: rd_byte = cnt_q;
      IDX_FLAGS: rd_byte = flags_q;
      IDX_MASK: rd_byte = mask_q;
      default: rd_byte = RESET_BYTE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_known ? rd_byte : RESET_BYTE};
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Oscillator pin synchroniser; the second and third stages feed the rising-edge detect
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= ext_osc_input;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign osc_rise = osc_s2_q && !osc_s3_q;

  // Source select and pin ownership
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      async_sel_q <= 1'b0;
      osc_pins_claimed <= 1'b0;
      osc_run <= 1'b0;
    end else begin
      if (wr_hit_status) begin
        async_sel_q <= wr_data_q[STAT_ASYNC_BIT];
      end
      osc_pins_claimed <= async_sel_q;
      osc_run <= async_sel_q && !power_down;
    end
  end

  assign src_tick = async_sel_q ? osc_rise : 1'b1;

  always_comb begin
    case (ctl.cs)
      3'h2: presc_last = DIV8_LAST;
      3'h3: presc_last = DIV32_LAST;
      3'h4: presc_last = DIV64_LAST;
      3'h5: presc_last = DIV128_LAST;
      3'h6: presc_last = DIV256_LAST;
      3'h7: presc_last = DIV1024_LAST;
      default: presc_last = DIV1_LAST;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_q <= 10'h000;
    end else if (ctl.cs == 3'h0) begin
      presc_q <= 10'h000;
    end else if (src_tick) begin
      presc_q <= (presc_q >= presc_last) ? 10'h000 : presc_q + 10'h001;
    end
  end

  assign tick = src_tick && ctl.cs != 3'h0 && presc_q >= presc_last;

  // Per-register staging; one entry never touches another
  for (genvar i = 0; i < ENTRY_NUM; i++) begin : g_stage
    // two-edge transfer; sync writes land at once
    assign load[i] = (wr_hit[i] && !async_sel_q)
      || (busy_q[i] && osc_rise && edges_q[i] == TRANSFER_EDGES - 2'h1);
    assign load_val[i] = wr_hit[i] ? wr_data_q : stage_q[i];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        stage_q[i] <= RESET_BYTE;
        busy_q[i] <= 1'b0;
        edges_q[i] <= 2'h0;
      end else if (wr_hit[i]) begin
        // busy set by an async write; rewrite restarts the count
        stage_q[i] <= wr_data_q;
        busy_q[i] <= async_sel_q;
        edges_q[i] <= 2'h0;
      end else if (load[i]) begin
        busy_q[i] <= 1'b0;
        edges_q[i] <= 2'h0;
      end else if (busy_q[i] && osc_rise) begin
        edges_q[i] <= edges_q[i] + 2'h1;
      end
    end
  end

  // Counter next value
  always_comb begin
    dir_up_d = dir_up_q;
    cnt_d = cnt_q;
    if (ctl.pwm) begin
      // up/down turn points; 510 ticks per round trip
      if (dir_up_q) begin
        if (cnt_q == CNT_TOP) begin
          dir_up_d = 1'b0;
          cnt_d = cnt_q - 8'h01;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end else begin
        if (cnt_q == CNT_BOTTOM) begin
          dir_up_d = 1'b1;
          cnt_d = cnt_q + 8'h01;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    end else begin
      dir_up_d = 1'b1;
      cnt_d = (ctl.ctc && cnt_q == compare_act_q) ? CNT_BOTTOM : cnt_q + 8'h01;
    end
  end

  // matching off while compare or count transfer pends
  assign match = tick && !busy_q[ENTRY_COMPARE] && !busy_q[ENTRY_COUNT]
    && cnt_d == compare_act_q;
  // pwm overflow leaving zero; normal overflow on wrap
  assign ev.ovf = tick && (ctl.pwm ? cnt_q == CNT_BOTTOM : cnt_q == CNT_TOP);
  assign ev.cmp = match;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= RESET_BYTE;
      dir_up_q <= 1'b1;
    end else if (load[ENTRY_COUNT]) begin
      cnt_q <= load_val[ENTRY_COUNT];
    end else if (tick) begin
      cnt_q <= cnt_d;
      dir_up_q <= dir_up_d;
    end
  end

  // control destination, bit 6 is the pwm switch
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_q <= RESET_BYTE;
    end else if (load[ENTRY_CONTROL]) begin
      control_q <= load_val[ENTRY_CONTROL] & CTRL_WRITE_MASK;
    end
  end

  // pwm holding copy promoted at top; normal mode takes it straight
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_hold_q <= RESET_BYTE;
      compare_act_q <= RESET_BYTE;
    end else begin
      if (load[ENTRY_COMPARE]) begin
        compare_hold_q <= load_val[ENTRY_COMPARE];
      end
      if (!ctl.pwm && load[ENTRY_COMPARE]) begin
        compare_act_q <= load_val[ENTRY_COMPARE];
      end else if (ctl.pwm && tick && cnt_d == CNT_TOP) begin
        compare_act_q <= compare_hold_q;
      end
    end
  end

  // Compare pin; driven only from timer ticks and the active value
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_output_pin <= 1'b0;
      compare_output_oe <= 1'b0;
    end else if (ctl.pwm) begin
      // modes 0 and 1 leave the pin free
      compare_output_oe <= ctl.mode[1];
      if (ctl.mode[1]) begin
        if (compare_act_q == CNT_BOTTOM) begin
          compare_output_pin <= ctl.mode[0];
        end else if (compare_act_q == CNT_TOP) begin
          compare_output_pin <= !ctl.mode[0];
        // pin moves on the timer tick; direction picks the level
        end else if (match) begin
          compare_output_pin <= dir_up_q ? ctl.mode[0] : !ctl.mode[0];
        end
      end
    end else begin
      compare_output_oe <= ctl.mode != 2'h0;
      if (match) begin
        case (ctl.mode)
          2'h1: compare_output_pin <= !compare_output_pin;
          2'h2: compare_output_pin <= 1'b0;
          2'h3: compare_output_pin <= 1'b1;
          default: compare_output_pin <= compare_output_pin;
        endcase
      end
    end
  end

  // async events reach the flags three cycles late
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < FLAG_SYNC_CYCLES; k++) begin
        ev_pipe_q[k] <= '0;
      end
    end else begin
      ev_pipe_q[0] <= ev;
      for (int k = 1; k < FLAG_SYNC_CYCLES; k++) begin
        ev_pipe_q[k] <= ev_pipe_q[k-1];
      end
    end
  end

  assign ev_set = async_sel_q ? ev_pipe_q[FLAG_SYNC_CYCLES-1] : ev;

  // Flags clear by writing one; a same-cycle event keeps the flag
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= RESET_BYTE;
      mask_q <= RESET_BYTE;
    end else begin
      if (wr_hit_mask) begin
        mask_q <= wr_data_q;
      end
      if (ev_set.ovf) begin
        flags_q[FLAG_OVF_BIT] <= 1'b1;
      end else if (wr_hit_flags && wr_data_q[FLAG_OVF_BIT]) begin
        flags_q[FLAG_OVF_BIT] <= 1'b0;
      end
      if (ev_set.cmp) begin
        flags_q[FLAG_CMP_BIT] <= 1'b1;
      end else if (wr_hit_flags && wr_data_q[FLAG_CMP_BIT]) begin
        flags_q[FLAG_CMP_BIT] <= 1'b0;
      end
    end
  end

  // flag, own enable and global enable
  assign irq_ovf = flags_q[FLAG_OVF_BIT] && mask_q[FLAG_OVF_BIT] && mask_q[MASK_GLOBAL_BIT];
  assign irq_cmp = flags_q[FLAG_CMP_BIT] && mask_q[FLAG_CMP_BIT] && mask_q[MASK_GLOBAL_BIT];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_irq_req <= 1'b0;
      compare_irq_req <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      overflow_irq_req <= irq_ovf;
      compare_irq_req <= irq_cmp;
      // wake raised on the next timer tick while async is selected
      if (async_sel_q && tick && (irq_ovf || irq_cmp)) begin
        wake_req <= 1'b1;
      // released once the request is gone, on an oscillator edge while async is selected, else at once
      end else if (!(irq_ovf || irq_cmp) && (osc_rise || !async_sel_q)) begin
        wake_req <= 1'b0;
      end
    end
  end

endmodule

// *** async_pwm_timer_asserts.sv ***
`timescale 1ns/1ps
module async_pwm_timer_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator
  input wire logic power_down,
  input wire logic osc_pins_claimed,
  input wire logic osc_run
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  rd_answer_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read answer missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  w_release_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channel not released");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read upper bits not zero");
  osc_gate_a: assert property (osc_run == (osc_pins_claimed && !$past(power_down)))
    else $error("oscillator run wrong");
endmodule

// *** async_pwm_timer_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module async_pwm_timer_tb;
  import async_pwm_timer_pkg::*;
  logic ref_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ext_osc_input, power_down, osc_en;
  logic osc_pins_claimed, osc_run, compare_output_pin, compare_output_oe;
  logic overflow_irq_req, compare_irq_req, wake_req;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rval;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wresp, rrsp;
  logic [2:0] osc_div;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  async_pwm_timer #(.ADDR_W(8)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_osc_input(ext_osc_input), .power_down(power_down),
    .osc_pins_claimed(osc_pins_claimed), .osc_run(osc_run),
    .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe),
    .overflow_irq_req(overflow_irq_req), .compare_irq_req(compare_irq_req),
    .wake_req(wake_req)
  );

  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Oscillator stands still until enabled; period is eight system cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    osc_div <= osc_div + 3'h1;
    ext_osc_input <= osc_en & osc_div[2];
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bit a, w;
    a = 0;
    w = 0;
    awaddr <= {idx[5:0], 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(a && w)) begin
      @(posedge ref_clk);
      if (awready && !a) begin
        a = 1;
        awvalid <= 1'h0;
      end
      if (wready && !w) begin
        w = 1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1) @(posedge ref_clk);
    wresp = bresp;
    bready <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] idx);
    araddr <= {idx[5:0], 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge ref_clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge ref_clk);
    rval = rdata;
    rrsp = rresp;
    rready <= 1'h0;
    @(posedge ref_clk);
  endtask

  // Counts one full high phase then the following low phase
  task automatic widths(output int hi, output int lo);
    hi = 0;
    lo = 0;
    while (compare_output_pin !== 1'h0) @(posedge ref_clk);
    while (compare_output_pin !== 1'h1) @(posedge ref_clk);
    while (compare_output_pin === 1'h1) begin
      @(posedge ref_clk);
      hi++;
    end
    while (compare_output_pin === 1'h0) begin
      @(posedge ref_clk);
      lo++;
    end
  endtask

  task automatic t_reset_bus();
    `CHK("outputs", 4'h0, {compare_output_pin, compare_output_oe, overflow_irq_req, compare_irq_req})
    rd(IDX_STATUS);
    `CHK("status reset", 32'h00, rval)
    rd(IDX_CONTROL);
    `CHK("control reset", 32'h00, rval)
    wr(8'h10, 8'h55);
    `CHK("unmapped write", RESP_SLVERR, wresp)
    rd(8'h10);
    `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {rrsp, rval})
  endtask

  task automatic t_pwm();
    int hi, lo;
    wr(IDX_COMPARE, 8'h80);
    wr(IDX_CONTROL, 8'h61);
    widths(hi, lo);
    `CHK("high time", 256, hi)
    `CHK("period", 510, hi + lo)
    `CHK("pin enable", 1'h1, compare_output_oe)
    // new value waits for the top
    wr(IDX_COMPARE, 8'h40);
    rd(IDX_COMPARE);
    `CHK("compare readback", 32'h40, rval)
    hi = 0;
    while (compare_output_pin === 1'h1) begin
      @(posedge ref_clk);
      hi++;
    end
    `CHK("deferred load", 1'h1, hi > 200)
    widths(hi, lo);
    `CHK("high time new", 128, hi)
    wr(IDX_CONTROL, 8'h71);
    widths(hi, lo);
    `CHK("inverted high", 382, hi)
    `CHK("inverted period", 510, hi + lo)
    for (int i = 0; i < 4; i++) begin
      wr(IDX_COMPARE, i[1] ? 8'h00 : 8'hFF);
      wr(IDX_CONTROL, i[0] ? 8'h61 : 8'h71);
      repeat (520) @(posedge ref_clk);
      `CHK("forced pin", i[0] ^ i[1], compare_output_pin)
    end
    for (int j = 0; j < 2; j++) begin
      wr(IDX_CONTROL, j ? 8'h51 : 8'h41);
      repeat (3) @(posedge ref_clk);
      `CHK("pin released", 1'h0, compare_output_oe)
    end
  endtask

  task automatic t_irq();
    wr(IDX_CONTROL, 8'h61);
    wr(IDX_COMPARE, 8'h40);
    wr(IDX_FLAGS, 8'h03);
    wr(IDX_MASK, 8'h03);
    repeat (520) @(posedge ref_clk);
    `CHK("irq gated", 2'h0, {overflow_irq_req, compare_irq_req})
    rd(IDX_FLAGS);
    `CHK("flags", 32'h03, rval)
    wr(IDX_MASK, 8'h81);
    repeat (2) @(posedge ref_clk);
    `CHK("overflow irq", 2'h2, {overflow_irq_req, compare_irq_req})
    wr(IDX_FLAGS, 8'h01);
    repeat (2) @(posedge ref_clk);
    `CHK("irq cleared", 2'h0, {overflow_irq_req, compare_irq_req})
    wr(IDX_MASK, 8'h82);
    repeat (2) @(posedge ref_clk);
    `CHK("compare irq", 2'h1, {overflow_irq_req, compare_irq_req})
    wr(IDX_MASK, 8'h00);
  endtask

  task automatic t_async();
    logic [31:0] c;
    // Normal mode with the ctc bit set clears the count on a match
    wr(IDX_CONTROL, 8'h19);
    wr(IDX_COMPARE, 8'h05);
    repeat (300) @(posedge ref_clk);
    rd(IDX_COUNT);
    `CHK("clear on match", 1'h1, rval < 32'h06)
    wr(IDX_CONTROL, 8'h00);
    rd(IDX_COUNT);
    c = rval;
    repeat (20) @(posedge ref_clk);
    rd(IDX_COUNT);
    `CHK("stopped count", c, rval)
    wr(IDX_STATUS, 8'h08);
    repeat (2) @(posedge ref_clk);
    `CHK("pins claimed", 2'h3, {osc_pins_claimed, osc_run})
    power_down <= 1'h1;
    repeat (2) @(posedge ref_clk);
    `CHK("osc in power-down", 1'h0, osc_run)
    power_down <= 1'h0;
    // each staged write raises its busy bit
    wr(IDX_COMPARE, 8'h33);
    wr(IDX_COUNT, 8'h10);
    wr(IDX_CONTROL, 8'h61);
    rd(IDX_STATUS);
    `CHK("busy set", 32'h0F, rval)
    rd(IDX_CONTROL);
    `CHK("control staging", 32'h61, rval)
    repeat (50) @(posedge ref_clk);
    rd(IDX_STATUS);
    `CHK("busy held", 32'h0F, rval)
    // Two oscillator edges plus synchroniser fit well inside 60 cycles
    osc_en <= 1'h1;
    repeat (60) @(posedge ref_clk);
    rd(IDX_STATUS);
    `CHK("busy cleared", 32'h08, rval)
    rd(IDX_COMPARE);
    `CHK("compare kept", 32'h33, rval)
    rd(IDX_COUNT);
    c = rval;
    repeat (40) @(posedge ref_clk);
    rd(IDX_COUNT);
    `CHK("live count", 1'h1, c !== rval)
    wr(IDX_FLAGS, 8'h03);
    wr(IDX_MASK, 8'h81);
    wr(IDX_COUNT, 8'h00);
    repeat (60) @(posedge ref_clk);
    `CHK("wake raised", 2'h3, {overflow_irq_req, wake_req})
    wr(IDX_FLAGS, 8'h01);
    repeat (20) @(posedge ref_clk);
    `CHK("wake released", 2'h0, {overflow_irq_req, wake_req})
  endtask

  initial begin
    sys_rst = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready, power_down, osc_en} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    osc_div = 3'h0;
    ext_osc_input = 1'h0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'h0;
    @(posedge ref_clk);
    t_reset_bus();
    t_pwm();
    t_irq();
    t_async();
    conclude();
  end
endmodule

bind async_pwm_timer async_pwm_timer_asserts chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .power_down(power_down),
  .osc_pins_claimed(osc_pins_claimed), .osc_run(osc_run)
);
